// [design/squib_map.svh]
// Function
// - $3X clears selected channel firing-time registers
// - Nominal load: no shutdown before 2.09 ms
// - Shorted load: shutdown only within 2.09-2.82 ms
// - Overtemp sets thermal bit; $7F latches them
// - Latch shifted next transfer, cleared then
// - Fire only when channel thermal status zero
// - FET test: unlock byte then test byte
// - Unlock accepted only with both permits low
// - Unlock bytes echoed on next transfer
// - Any fire permit aborts FET test
// - Unlock suspends diagnostics until second byte
// - After high unlock, $1X tests high drivers
// - After low unlock, $2X tests low drivers
// - Test drive current limited, host ends test
// - Any unlock stops running FET test
// - Any driver combination on one side testable by one command; high and low never together
// - Test fail bit one means driver off
// - Test status shifted out next transfer
// - Unlock at chip-select rise clears fail bits
// - Both permits low block firing, diagnostics remain
// - Reset pin low clears everything except thermal status
`ifndef SQUIB_MAP_SVH
`define SQUIB_MAP_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_NOP          8'h00
`define CMD_THERM_STAT   8'h7f
`define CMD_HS_UNLOCK    8'h82
`define CMD_LS_UNLOCK    8'h83
`define CMD_MEAS_RST_HI  4'h3
`define CMD_HS_TEST_HI   4'h1
`define CMD_LS_TEST_HI   4'h2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define FIRE_TIME_RST    8'h00
`define FIRE_TIME_MAX    8'hff
`define CLK_PERIOD_PS    4000
// The longest picosecond span exceeds a 32-bit int, so they are kept at 64 bits
`define THERM_MIN_PS     64'd2090000000
`define THERM_MAX_PS     64'd2820000000
`define MEAS_STEP_PS     64'd1000000000
`define SPI_BITS         4'h8

`endif

// [design/squib_pkg.sv]
package squib_pkg;

   typedef enum logic [1:0] {
      UNLOCK_NONE = 2'b00,
      UNLOCK_HS   = 2'b01,
      UNLOCK_LS   = 2'b10
   } unlock_e;

   typedef enum logic [1:0] {
      TX_ZERO   = 2'b00,
      TX_ECHO   = 2'b01,
      TX_THERM  = 2'b10,
      TX_FET    = 2'b11
   } tx_sel_e;

   typedef logic [19:0] on_time_t;

endpackage : squib_pkg

// [design/spi_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
   logic       byte_stb;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   modport shifter (output byte_stb, output rx_byte, input tx_byte);
   modport core    (input byte_stb, input rx_byte, output tx_byte);
endinterface : spi_link_if
`default_nettype wire

// [design/spi_shifter.sv]
`timescale 1ns/100ps
`default_nettype none
`include "squib_map.svh"
module spi_shifter (
   // Clock and reset
   input  wire logic   clock,
   input  wire logic   rst,
   // Serial pins
   input  wire logic   cs_n,
   input  wire logic   sclk,
   input  wire logic   mosi,
   output logic        miso,
   output logic        miso_oe,
   // Core side
   spi_link_if.shifter link
);
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [1:0] last;
      logic [7:0] rx;
      logic [7:0] tx;
      logic [3:0] count;
      logic       stb;
      logic       miso;
      logic       oe;
   } shift_s;

   shift_s state_reg;
   shift_s state_next;

   logic cs_rise;
   logic cs_fall;
   logic clk_rise;
   logic clk_fall;

   // ----------------------------------------
   // Pin edges, from the second sync stage only
   // ----------------------------------------
   assign cs_rise  = state_reg.sync2[2] & ~state_reg.last[1];
   assign cs_fall  = ~state_reg.sync2[2] & state_reg.last[1];
   assign clk_rise = state_reg.sync2[1] & ~state_reg.last[0] & ~state_reg.sync2[2];
   assign clk_fall = ~state_reg.sync2[1] & state_reg.last[0] & ~state_reg.sync2[2];

   always_comb begin
      state_next       = state_reg;
      state_next.sync1 = {cs_n, sclk, mosi};
      state_next.sync2 = state_reg.sync1;
      state_next.last  = state_reg.sync2[2:1];
      state_next.stb   = 1'b0;
      if (cs_fall) begin
         state_next.tx    = link.tx_byte;
         state_next.miso  = link.tx_byte[7];
         state_next.oe    = 1'b1;
         state_next.count = 4'h0;
      end
      if (clk_rise) begin
         state_next.rx    = {state_reg.rx[6:0], state_reg.sync2[0]};
         state_next.count = state_reg.count + 4'h1;
      end
      if (clk_fall) begin
         state_next.tx   = {state_reg.tx[6:0], 1'b0};
         state_next.miso = state_reg.tx[6];
      end
      if (cs_rise) begin
         state_next.oe  = 1'b0;
         state_next.stb = (state_reg.count == `SPI_BITS);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // Idle pin levels, so no false edge follows reset
         state_reg <= '{sync1: 3'h4, sync2: 3'h4, last: 2'h2, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign miso          = state_reg.miso;
   assign miso_oe       = state_reg.oe;
   assign link.byte_stb = state_reg.stb;
   assign link.rx_byte  = state_reg.rx;
endmodule : spi_shifter
`default_nettype wire

// [design/squib_diag_command_logic.sv]
`timescale 1ns/100ps
`default_nettype none
`include "squib_map.svh"
module squib_diag_command_logic #(
   parameter int THERM_MIN_CYC =
      int'((`THERM_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS),
   parameter int THERM_MAX_CYC = int'(`THERM_MAX_PS / `CLK_PERIOD_PS),
   parameter int MEAS_STEP_CYC = int'(`MEAS_STEP_PS / `CLK_PERIOD_PS)
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        reset_pin_n,
   // Serial link
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe,
   // Fire permits
   input  wire logic        fire_permit_in_one,
   input  wire logic        fire_permit_in_two,
   // Channel analog status
   input  wire logic [3:0]  over_temp,
   input  wire logic [3:0]  shorted_load,
   input  wire logic [3:0]  current_above,
   input  wire logic [3:0]  hs_turned_on,
   input  wire logic [3:0]  ls_turned_on,
   // Arm and fire request, same clock
   input  wire logic [3:0]  fire_request,
   // Driver controls
   output logic [3:0]       squib_drive_on,
   output logic [3:0]       hs_test_drive,
   output logic [3:0]       ls_test_drive,
   output logic             diag_suspended,
   // Status
   output logic [3:0]       thermal_status,
   output logic [3:0]       high_side_test_fail,
   output logic [3:0]       low_side_test_fail,
   output logic [31:0]      fire_time
);
   localparam int NPIN = 23;

   typedef struct packed {
      logic [NPIN-1:0]             sync1;
      logic [NPIN-1:0]             sync2;
      squib_pkg::unlock_e          unlock;
      squib_pkg::tx_sel_e          tx_sel;
      logic [7:0]                  echo;
      logic                        suspend;
      logic [3:0]                  therm;
      logic [3:0]                  therm_latch;
      logic                        latch_pending;
      logic [3:0]                  hs_test;
      logic [3:0]                  ls_test;
      logic [3:0]                  hs_fail;
      logic [3:0]                  ls_fail;
      logic [3:0]                  drive;
      logic [3:0][19:0]            on_time;
      logic [3:0][7:0]             fire_time;
      logic [31:0]                 step_cnt;
   } core_s;

   core_s state_reg;
   core_s state_next;

   spi_link_if link ();

   logic       pin_rst_n;
   logic [1:0] permit;
   logic [3:0] hot;
   logic [3:0] shorted;
   logic [3:0] above;
   logic [3:0] hs_on;
   logic [3:0] ls_on;
   logic       step;
   logic       unlock_ok;
   logic [7:0] cmd;
   logic       stb;

   logic [3:0]       shut;
   logic [3:0][19:0] on_time_next;
   logic [3:0][7:0]  fire_time_next;
   logic [3:0]       drive_next;

   // ----------------------------------------
   // Serial shifter
   // ----------------------------------------
   spi_shifter u_shifter (
      .clock   (clock),
      .rst     (rst),
      .cs_n    (cs_n),
      .sclk    (sclk),
      .mosi    (mosi),
      .miso    (miso),
      .miso_oe (miso_oe),
      .link    (link.shifter)
   );

   // ----------------------------------------
   // Synchronised pins, second stage only
   // ----------------------------------------
   assign pin_rst_n = state_reg.sync2[22];
   assign permit    = state_reg.sync2[21:20];
   assign hot       = state_reg.sync2[19:16];
   assign shorted   = state_reg.sync2[15:12];
   assign above     = state_reg.sync2[11:8];
   assign hs_on     = state_reg.sync2[7:4];
   assign ls_on     = state_reg.sync2[3:0];

   assign step      = (state_reg.step_cnt == 32'(MEAS_STEP_CYC - 1));
   assign cmd       = link.rx_byte;
   assign stb       = link.byte_stb;
   assign unlock_ok = (permit == 2'b00);

   // ----------------------------------------
   // Per-channel firing, timers and thermal
   // ----------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_ch
         // Thermal cutoff never before the minimum on time, and a
         // shorted load is cut by the maximum even without the sensor
         assign shut[ch] = state_reg.drive[ch] &
            ((hot[ch] && state_reg.on_time[ch] >= 20'(THERM_MIN_CYC)) |
             (shorted[ch] && state_reg.on_time[ch] >= 20'(THERM_MAX_CYC)));
         // Each channel is gated only by its own thermal bit
         assign drive_next[ch] = fire_request[ch] & ~state_reg.therm[ch] & ~shut[ch] &
                                 (permit != 2'b00) & pin_rst_n;
         assign on_time_next[ch] = !state_reg.drive[ch] ? 20'h0 :
            (state_reg.on_time[ch] == 20'hfffff) ? state_reg.on_time[ch] :
            state_reg.on_time[ch] + 20'h1;
         always_comb begin
            fire_time_next[ch] = state_reg.fire_time[ch];
            if (state_reg.drive[ch] && above[ch] && step &&
                state_reg.fire_time[ch] != `FIRE_TIME_MAX) begin
               fire_time_next[ch] = state_reg.fire_time[ch] + 8'h01;
            end
            if (stb && !state_reg.suspend && cmd[7:4] == `CMD_MEAS_RST_HI &&
                cmd[ch]) begin
               fire_time_next[ch] = `FIRE_TIME_RST;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Command interpreter
   // ----------------------------------------
   always_comb begin
      state_next       = state_reg;
      state_next.sync1 = {reset_pin_n, fire_permit_in_two, fire_permit_in_one, over_temp,
                          shorted_load, current_above, hs_turned_on, ls_turned_on};
      state_next.sync2 = state_reg.sync1;
      state_next.step_cnt = step ? 32'h0 : state_reg.step_cnt + 32'h1;
      state_next.drive     = drive_next;
      state_next.on_time   = on_time_next;
      state_next.fire_time = fire_time_next;

      // Thermal bit follows the cutoff and drops at re-enable temperature
      state_next.therm = (state_reg.therm & hot) | shut;

      // Fail bits set, and stay set, when a tested driver reports off
      state_next.hs_fail = state_reg.hs_fail | (state_reg.hs_test & ~hs_on);
      state_next.ls_fail = state_reg.ls_fail | (state_reg.ls_test & ~ls_on);

      if (stb) begin
         state_next.tx_sel = squib_pkg::TX_ZERO;
         // Latch is consumed by this transfer; a new $7F relatches below
         if (state_reg.latch_pending) begin
            state_next.therm_latch   = 4'h0;
            state_next.latch_pending = 1'b0;
         end
         if ((cmd == `CMD_HS_UNLOCK || cmd == `CMD_LS_UNLOCK) && unlock_ok) begin
            state_next.unlock  = (cmd == `CMD_HS_UNLOCK) ? squib_pkg::UNLOCK_HS :
                                 squib_pkg::UNLOCK_LS;
            state_next.hs_test = 4'h0;
            state_next.ls_test = 4'h0;
            state_next.hs_fail = 4'h0;
            state_next.ls_fail = 4'h0;
            state_next.suspend = 1'b1;
            state_next.therm_latch   = 4'h0;
            state_next.latch_pending = 1'b0;
            state_next.echo    = cmd;
            state_next.tx_sel  = squib_pkg::TX_ECHO;
         end else if (cmd == `CMD_HS_UNLOCK || cmd == `CMD_LS_UNLOCK) begin
            state_next.echo   = cmd;
            state_next.tx_sel = squib_pkg::TX_ECHO;
         end else if (state_reg.suspend) begin
            // Second byte ends the sequence unless it is an unlock byte
            state_next.suspend = 1'b0;
            state_next.unlock  = squib_pkg::UNLOCK_NONE;
            // Unlock cleared both test sets, so the low nibble alone picks the channels
            if (state_reg.unlock == squib_pkg::UNLOCK_HS &&
                cmd[7:4] == `CMD_HS_TEST_HI) begin
               state_next.hs_test = state_reg.hs_test | cmd[3:0];
               state_next.ls_test = 4'h0;
               state_next.tx_sel  = squib_pkg::TX_FET;
            end else if (state_reg.unlock == squib_pkg::UNLOCK_LS &&
                         cmd[7:4] == `CMD_LS_TEST_HI) begin
               state_next.ls_test = state_reg.ls_test | cmd[3:0];
               state_next.hs_test = 4'h0;
               state_next.tx_sel  = squib_pkg::TX_FET;
            end
         end else if (cmd == `CMD_THERM_STAT) begin
            state_next.therm_latch   = state_reg.therm;
            state_next.latch_pending = 1'b1;
            state_next.tx_sel        = squib_pkg::TX_THERM;
         end
      end

      // Firing enabled by either permit stops any test at once
      if (permit != 2'b00) begin
         state_next.hs_test = 4'h0;
         state_next.ls_test = 4'h0;
      end

      // Reset pin low clears all functions and serial data except the thermal bits
      if (!pin_rst_n) begin
         state_next.unlock        = squib_pkg::UNLOCK_NONE;
         state_next.tx_sel        = squib_pkg::TX_ZERO;
         state_next.echo          = 8'h00;
         state_next.suspend       = 1'b0;
         state_next.therm_latch   = 4'h0;
         state_next.latch_pending = 1'b0;
         state_next.hs_test       = 4'h0;
         state_next.ls_test       = 4'h0;
         state_next.hs_fail       = 4'h0;
         state_next.ls_fail       = 4'h0;
         state_next.drive         = 4'h0;
         state_next.on_time       = '0;
         state_next.fire_time     = '0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Reply byte for the next transfer
   // ----------------------------------------
   always_comb begin
      case (state_reg.tx_sel)
         squib_pkg::TX_ECHO:  link.tx_byte = state_reg.echo;
         squib_pkg::TX_THERM: link.tx_byte = {4'h0, state_reg.therm_latch};
         squib_pkg::TX_FET:   link.tx_byte = {state_reg.ls_fail, state_reg.hs_fail};
         default:             link.tx_byte = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Outputs, all from state flip-flops
   // ----------------------------------------
   // Test drive current limit sits in the analog stage
   assign squib_drive_on      = state_reg.drive;
   assign hs_test_drive       = state_reg.hs_test;
   assign ls_test_drive       = state_reg.ls_test;
   assign diag_suspended      = state_reg.suspend;
   assign thermal_status      = state_reg.therm;
   assign high_side_test_fail = state_reg.hs_fail;
   assign low_side_test_fail  = state_reg.ls_fail;
   assign fire_time           = state_reg.fire_time;
endmodule : squib_diag_command_logic
`default_nettype wire

// [testbench/spi_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------
// SPI master, mode 0, MSB first
// ----------
module spi_master_model (
   // Serial pins
   output var logic cs_n,
   output var logic sclk,
   output var logic mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // Exactly eight clocks per frame; sclk stands still outside frames
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n = 1'b0;
      mosi = tx[7];
      #62.5;
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b1;
         rx[i] = miso_oe ? miso : 1'bx;
         #62.5;
         sclk = 1'b0;
         // Released data line shows the inverse so a stale bit never passes
         mosi = (i > 0) ? tx[i-1] : ~mosi;
         #62.5;
      end
      cs_n = 1'b1;
      #100;
   endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// [testbench/squib_diag_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------
// Port checks
// ----------
module squib_diag_asserts (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       reset_pin_n,
   // Link and permits
   input wire logic       cs_n,
   input wire logic       miso_oe,
   input wire logic       fire_permit_in_one,
   input wire logic       fire_permit_in_two,
   // Drivers and status
   input wire logic [3:0] squib_drive_on,
   input wire logic [3:0] hs_test_drive,
   input wire logic [3:0] ls_test_drive,
   input wire logic       diag_suspended,
   input wire logic [3:0] thermal_status,
   input wire logic [3:0] high_side_test_fail,
   input wire logic [3:0] low_side_test_fail
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Inputs pass two sync stages, so four quiet cycles leave margin
   property p_permit_off; (!fire_permit_in_one && !fire_permit_in_two) [*4] |=> squib_drive_on == 4'h0; endproperty
   a_permit_off: assert property (p_permit_off) else $error("drive on without permit");
   property p_test_abort; (fire_permit_in_one || fire_permit_in_two) [*4] |=> (hs_test_drive | ls_test_drive) == 4'h0; endproperty
   a_test_abort: assert property (p_test_abort) else $error("test drive with permit");
   property p_no_overlap; !((|hs_test_drive) && (|ls_test_drive)); endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both test sides on");
   property p_thermal_gate; (squib_drive_on & thermal_status & $past(thermal_status)) == 4'h0; endproperty
   a_thermal_gate: assert property (p_thermal_gate) else $error("drive on while hot");
   property p_pin_reset; !reset_pin_n [*4] |=> (squib_drive_on | hs_test_drive | ls_test_drive | high_side_test_fail | low_side_test_fail) == 4'h0 && !diag_suspended; endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("state kept in pin reset");
   property p_oe_idle; cs_n [*5] |=> !miso_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("data out driven while idle");
   property p_suspend_stable; (cs_n && reset_pin_n) [*8] |=> $stable(diag_suspended); endproperty
   a_suspend_stable: assert property (p_suspend_stable) else $error("suspend moved without frame");
   property p_hs_fail_cause; (high_side_test_fail & ~$past(high_side_test_fail) & ~hs_test_drive & ~$past(hs_test_drive)) == 4'h0; endproperty
   a_hs_fail_cause: assert property (p_hs_fail_cause) else $error("high fail without test");
   property p_ls_fail_cause; (low_side_test_fail & ~$past(low_side_test_fail) & ~ls_test_drive & ~$past(ls_test_drive)) == 4'h0; endproperty
   a_ls_fail_cause: assert property (p_ls_fail_cause) else $error("low fail without test");
endmodule : squib_diag_asserts
bind squib_diag_command_logic squib_diag_asserts chk_u (.clock, .rst, .reset_pin_n, .cs_n,
   .miso_oe, .fire_permit_in_one, .fire_permit_in_two, .squib_drive_on, .hs_test_drive,
   .ls_test_drive, .diag_suspended, .thermal_status, .high_side_test_fail, .low_side_test_fail);
`default_nettype wire

// [testbench/squib_diag_command_logic_test.sv]
`timescale 1ns/100ps
`default_nettype none
module squib_diag_command_logic_test;
   logic            clock, rst, reset_pin_n, fire_permit_in_one, fire_permit_in_two;
   logic [3:0]      over_temp, shorted_load, current_above, hs_turned_on, ls_turned_on;
   logic [3:0]      fire_request;
   wire logic       cs_n, sclk, mosi, miso, miso_oe, diag_suspended;
   wire logic [3:0] squib_drive_on, hs_test_drive, ls_test_drive, thermal_status;
   wire logic [3:0] high_side_test_fail, low_side_test_fail;
   wire logic [31:0] fire_time;
   logic [7:0]      rx;
   logic [31:0]     saved;
   int              num_errors = 0;
   int              total_checks = 0;
   // Short thermal and step counts keep the run brief
   squib_diag_command_logic #(.THERM_MIN_CYC(50), .THERM_MAX_CYC(80), .MEAS_STEP_CYC(4)) dut_u (
      .clock, .rst, .reset_pin_n, .cs_n, .sclk, .mosi, .miso, .miso_oe, .fire_permit_in_one,
      .fire_permit_in_two, .over_temp, .shorted_load, .current_above, .hs_turned_on,
      .ls_turned_on, .fire_request, .squib_drive_on, .hs_test_drive, .ls_test_drive,
      .diag_suspended, .thermal_status, .high_side_test_fail, .low_side_test_fail, .fire_time);
   spi_master_model master_u (.cs_n, .sclk, .mosi, .miso, .miso_oe);
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic xfer(input logic [7:0] tx);
      master_u.xfer(tx, rx);
      step(1);
   endtask : xfer
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic test_reset_values;
      check("fire_time", fire_time, 32'h0);
      check("fail", 32'({high_side_test_fail, low_side_test_fail}), 32'h0);
      $display("reset values done");
   endtask : test_reset_values
   task automatic test_fet;
      hs_turned_on = 4'h5;
      ls_turned_on = 4'h1;
      xfer(8'h82);
      check("suspended", 32'(diag_suspended), 32'h1);
      xfer(8'h1f);
      check("echo", 32'(rx), 32'h82);
      check("suspended", 32'(diag_suspended), 32'h0);
      check("hs_drive", 32'(hs_test_drive), 32'hf);
      check("hs_fail", 32'(high_side_test_fail), 32'ha);
      xfer(8'h83);
      check("reply", 32'(rx), 32'h0a);
      check("hs_drive", 32'(hs_test_drive), 32'h0);
      check("hs_fail", 32'(high_side_test_fail), 32'h0);
      xfer(8'h23);
      check("echo", 32'(rx), 32'h83);
      check("ls_drive", 32'(ls_test_drive), 32'h3);
      xfer(8'h00);
      check("reply", 32'(rx), 32'h20);
      check("ls_drive", 32'(ls_test_drive), 32'h3);
      $display("fet test done");
   endtask : test_fet
   task automatic test_refused;
      fire_permit_in_one = 1'b1;
      step(5);
      check("ls_drive", 32'(ls_test_drive), 32'h0);
      xfer(8'h82);
      check("suspended", 32'(diag_suspended), 32'h0);
      xfer(8'h1f);
      check("echo", 32'(rx), 32'h82);
      check("hs_drive", 32'(hs_test_drive), 32'h0);
      fire_permit_in_one = 1'b0;
      $display("refused unlock done");
   endtask : test_refused
   task automatic test_thermal;
      fire_permit_in_two = 1'b1;
      over_temp = 4'h1;
      fire_request = 4'h3;
      step(5);
      check("drive", 32'(squib_drive_on), 32'h3);
      step(40);
      check("thermal", 32'(thermal_status), 32'h0);
      step(20);
      check("thermal", 32'(thermal_status), 32'h1);
      check("drive", 32'(squib_drive_on), 32'h2);
      xfer(8'h7f);
      xfer(8'h7f);
      check("reply", 32'(rx), 32'h01);
      over_temp = 4'h0;
      fire_request = 4'h0;
      step(5);
      xfer(8'h00);
      check("reply", 32'(rx), 32'h01);
      xfer(8'h00);
      check("reply", 32'(rx), 32'h00);
      // Shorted load may only shut down inside its window
      shorted_load = 4'h4;
      over_temp = 4'h4;
      fire_request = 4'h4;
      step(45);
      check("thermal", 32'(thermal_status), 32'h0);
      step(40);
      check("thermal", 32'(thermal_status), 32'h4);
      fire_request = 4'h0;
      over_temp = 4'h0;
      shorted_load = 4'h0;
      $display("thermal done");
   endtask : test_thermal
   task automatic test_meas_reset;
      current_above = 4'hf;
      fire_request = 4'hf;
      step(40);
      fire_request = 4'h0;
      fire_permit_in_two = 1'b0;
      step(5);
      saved = fire_time;
      check("counted", 32'(saved[7:0] > 8'h04), 32'h1);
      xfer(8'h35);
      check("fire_time", fire_time, {saved[31:24], 8'h00, saved[15:8], 8'h00});
      $display("measure reset done");
   endtask : test_meas_reset
   task automatic test_pin_reset;
      hs_turned_on = 4'h0;
      xfer(8'h82);
      xfer(8'h13);
      check("hs_drive", 32'(hs_test_drive), 32'h3);
      reset_pin_n = 1'b0;
      step(6);
      check("hs_drive", 32'(hs_test_drive), 32'h0);
      check("hs_fail", 32'(high_side_test_fail), 32'h0);
      check("fire_time", fire_time, 32'h0);
      reset_pin_n = 1'b1;
      step(4);
      $display("pin reset done");
   endtask : test_pin_reset
   initial begin
      rst = 1'b1;
      reset_pin_n = 1'b1;
      fire_permit_in_one = 1'b0;
      fire_permit_in_two = 1'b0;
      {over_temp, shorted_load, current_above, hs_turned_on, ls_turned_on} = 20'h0;
      fire_request = 4'h0;
      step(12);
      rst = 1'b0;
      step(4);
      test_reset_values;
      test_fet;
      test_refused;
      test_thermal;
      test_meas_reset;
      test_pin_reset;
      give_verdict;
   end
   // Whole run needs some 17 us; a hang is cut off well past that
   initial begin
      #100000;
      num_errors++;
      give_verdict;
   end
endmodule : squib_diag_command_logic_test
`default_nettype wire
